/* verilog/dcr_bank.sv */
// converter gain, power, cable presence, pin readback and soft reset register bank
`timescale 1ns/1ps
`include "dcr_regs.svh"
module dcr_bank #(
  parameter int BUS_WIDTH = 10
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_n_in,
  input  wire dcr_pkg::dcr_req_t       req_in,
  input  wire logic [BUS_WIDTH-1:0]    sd_bus_in,
  input  wire logic [BUS_WIDTH-1:0]    luma_bus_in,
  input  wire logic [BUS_WIDTH-1:0]    chroma_bus_in,
  input  wire dcr_pkg::dcr_ctrl_pins_t ctrl_pins_in,
  input  wire logic                    dac1_unconnected_in,
  input  wire logic                    dac2_unconnected_in,
  output logic [7:0]                   rdata_out,
  output logic                         rvalid_out,
  output dcr_pkg::dcr_gain_t           gain_out,
  output logic [`DCR_LP_WIDTH-1:0]     dac_low_power_out,
  output logic                         device_reset_out
);

  if (BUS_WIDTH != 10) begin : g_bad_bus
    $error("dcr_bank: readback layout needs BUS_WIDTH of 10");
  end

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  localparam int PIN_W = 3 * BUS_WIDTH + 6 + 2;

  logic [PIN_W-1:0] pins_sync;
  logic [9:0]       sd_s;
  logic [9:0]       luma_s;
  logic [9:0]       chroma_s;
  logic [5:0]       ctrl_s;
  logic [1:0]       unconn_s;

  // bus pins are asynchronous to the register clock, so every bit is synchronised
  dcr_pin_sync #(
    .WIDTH (PIN_W)
  ) u_pin_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_sync_q),
    .async_in   ({sd_bus_in, luma_bus_in, chroma_bus_in, ctrl_pins_in,
                  dac2_unconnected_in, dac1_unconnected_in}),
    .sync_out   (pins_sync)
  );

  always_comb begin
    {sd_s, luma_s, chroma_s, ctrl_s, unconn_s} = pins_sync;
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  logic [7:0]               gain_a_q;
  logic [7:0]               gain_a_d;
  logic [7:0]               gain_b_q;
  logic [7:0]               gain_b_d;
  logic [`DCR_LP_WIDTH-1:0] power_q;
  logic [`DCR_LP_WIDTH-1:0] power_d;
  logic                     auto_pd_q;
  logic                     auto_pd_d;
  logic                     soft_rst_q;
  logic                     soft_rst_d;

  always_comb begin
    gain_a_d   = gain_a_q;
    gain_b_d   = gain_b_q;
    power_d    = power_q;
    auto_pd_d  = auto_pd_q;
    soft_rst_d = 1'b0;
    if (soft_rst_q) begin
      // the reset cycle returns every control field to its reset value
      gain_a_d  = `DCR_RST_GAIN;
      gain_b_d  = `DCR_RST_GAIN;
      power_d   = `DCR_RST_POWER_MODE;
      auto_pd_d = `DCR_RST_AUTO_PD;
    end else if (req_in.wr) begin
      unique case (req_in.addr)
        `DCR_OFS_GAIN_A:     gain_a_d = req_in.wdata;
        `DCR_OFS_GAIN_B:     gain_b_d = req_in.wdata;
        `DCR_OFS_POWER_MODE: power_d = req_in.wdata[`DCR_LP_WIDTH-1:0];
        `DCR_OFS_CABLE:      auto_pd_d = req_in.wdata[`DCR_BIT_AUTO_PD];
        `DCR_OFS_SOFT_RESET: soft_rst_d = req_in.wdata[`DCR_BIT_SOFT_RESET];
        // readback registers and unmapped offsets ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gain_a_q   <= `DCR_RST_GAIN;
      gain_b_q   <= `DCR_RST_GAIN;
      power_q    <= `DCR_RST_POWER_MODE;
      auto_pd_q  <= `DCR_RST_AUTO_PD;
      soft_rst_q <= 1'b0;
    end else begin
      gain_a_q   <= gain_a_d;
      gain_b_q   <= gain_b_d;
      power_q    <= power_d;
      auto_pd_q  <= auto_pd_d;
      soft_rst_q <= soft_rst_d;
    end
  end

  // ----------------------------------------
  // converter drive
  // ----------------------------------------
  // codes beyond the trim range saturate rather than wrap, so a stray code never flips sign
  function automatic logic [7:0] dcr_clamp(input logic [7:0] code);
    logic [7:0] res;
    res = code;
    if (!code[7] && code > `DCR_GAIN_POS_MAX) begin
      res = `DCR_GAIN_POS_MAX;
    end else if (code[7] && code < `DCR_GAIN_NEG_MAX) begin
      res = `DCR_GAIN_NEG_MAX;
    end
    return res;
  endfunction : dcr_clamp

  dcr_pkg::dcr_gain_t       gain_q;
  dcr_pkg::dcr_gain_t       gain_d;
  logic [`DCR_LP_WIDTH-1:0] lp_q;
  logic [`DCR_LP_WIDTH-1:0] lp_d;

  always_comb begin
    gain_d.group_a = dcr_clamp(gain_a_q);
    gain_d.group_b = dcr_clamp(gain_b_q);
    lp_d           = power_q;
    if (auto_pd_q) begin
      // only converters one and two have a cable sense
      lp_d[0] = power_q[0] | unconn_s[0];
      lp_d[1] = power_q[1] | unconn_s[1];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      gain_q <= '0;
      lp_q   <= '0;
    end else begin
      gain_q <= gain_d;
      lp_q   <= lp_d;
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rvalid_q;
  logic       rvalid_d;

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = req_in.rd;
    if (req_in.rd) begin
      unique case (req_in.addr)
        `DCR_OFS_GAIN_A:      rdata_d = gain_a_q;
        `DCR_OFS_GAIN_B:      rdata_d = gain_b_q;
        `DCR_OFS_POWER_MODE:  rdata_d = {5'h00, power_q};
        `DCR_OFS_CABLE:       rdata_d = {3'h0, auto_pd_q, 2'h0, unconn_s};
        `DCR_OFS_SD_HIGH:     rdata_d = sd_s[9:2];
        `DCR_OFS_LUMA_HIGH:   rdata_d = luma_s[9:2];
        `DCR_OFS_CHROMA_HIGH: rdata_d = chroma_s[9:2];
        `DCR_OFS_LOW_BITS:    rdata_d = {2'h0, sd_s[1:0], luma_s[1:0], chroma_s[1:0]};
        `DCR_OFS_CTRL_PINS:   rdata_d = {2'h0, ctrl_s};
        `DCR_OFS_SOFT_RESET:  rdata_d = {6'h00, soft_rst_q, 1'b0};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    rdata_out         = rdata_q;
    rvalid_out        = rvalid_q;
    gain_out          = gain_q;
    dac_low_power_out = lp_q;
    device_reset_out  = soft_rst_q;
  end

endmodule : dcr_bank

/* verilog/dcr_regs.svh */
// register offsets, field positions and reset values of the converter control bank
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define DCR_OFS_GAIN_B      8'h0A
`define DCR_OFS_GAIN_A      8'h0B
`define DCR_OFS_POWER_MODE  8'h0D
`define DCR_OFS_CABLE       8'h10
`define DCR_OFS_SD_HIGH     8'h12
`define DCR_OFS_LUMA_HIGH   8'h13
`define DCR_OFS_CHROMA_HIGH 8'h14
`define DCR_OFS_LOW_BITS    8'h15
`define DCR_OFS_CTRL_PINS   8'h16
`define DCR_OFS_SOFT_RESET  8'h17

// ----------------------------------------
// field positions
// ----------------------------------------
`define DCR_BIT_CABLE_DAC1  0
`define DCR_BIT_CABLE_DAC2  1
`define DCR_BIT_AUTO_PD     4
`define DCR_BIT_SOFT_RESET  1
`define DCR_LP_WIDTH        3

// ----------------------------------------
// reset values and gain limits
// ----------------------------------------
`define DCR_RST_GAIN        8'h00
`define DCR_RST_POWER_MODE  3'h0
`define DCR_RST_AUTO_PD     1'h0
`define DCR_GAIN_POS_MAX    8'h40
`define DCR_GAIN_NEG_MAX    8'hC0

`endif

/* verilog/dcr_pkg.sv */
// types shared by the converter control bank
package dcr_pkg;

  // host-port register request, one access per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } dcr_req_t;

  // sampled control pins, blank in bit 0 up to serial-out/lock in bit 5
  typedef struct packed {
    logic subcarrier_lock_or_serial_out_pin;
    logic sd_hsync;
    logic sd_vsync;
    logic pixel_hsync;
    logic pixel_vsync;
    logic pixel_blank;
  } dcr_ctrl_pins_t;

  // gain trim handed to the two converter groups
  typedef struct packed {
    logic signed [7:0] group_a;
    logic signed [7:0] group_b;
  } dcr_gain_t;

endpackage : dcr_pkg

/* verilog/dcr_pin_sync.sv */
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
module dcr_pin_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (WIDTH < 1) begin : g_bad_width
    $error("dcr_pin_sync: WIDTH must be at least 1");
  end

  // ----------------------------------------
  // per-bit two-flop chain
  // ----------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q;
    logic meta_d;
    logic stable_q;
    logic stable_d;

    always_comb begin
      meta_d   = async_in[i];
      stable_d = meta_q;
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        meta_q   <= 1'b0;
        stable_q <= 1'b0;
      end else begin
        meta_q   <= meta_d;
        stable_q <= stable_d;
      end
    end

    assign sync_out[i] = stable_q;
  end

endmodule : dcr_pin_sync

/* tb/dcr_bank_properties.sv */
// port assertions for the converter control bank
`timescale 1ns/1ps
module dcr_bank_properties (
  input wire logic               clk_sys_in,
  input wire logic               rst_n_in,
  input wire dcr_pkg::dcr_req_t  req_in,
  input wire logic [7:0]         rdata_out,
  input wire logic               rvalid_out,
  input wire dcr_pkg::dcr_gain_t gain_out,
  input wire logic [2:0]         dac_low_power_out,
  input wire logic               device_reset_out
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  chk_read_answer: assert property (req_in.rd |=> rvalid_out)
    else $error("read got no answer");
  chk_no_stray_valid: assert property (rvalid_out |-> $past(req_in.rd))
    else $error("answer without a read");
  chk_rdata_holds: assert property (!rvalid_out |-> $stable(rdata_out))
    else $error("read data moved without a read");
  chk_low_bits_zero: assert property (rvalid_out && $past(req_in.addr) == 8'h15 |-> rdata_out[7:6] == 2'b00)
    else $error("low-bits readback top bits not zero");
  chk_low_power_bit: assert property (req_in.wr && req_in.addr == 8'h0D && !device_reset_out
    |-> ##2 dac_low_power_out[2] == $past(req_in.wdata[2], 2))
    else $error("converter three low power not following write");
  chk_reset_cause: assert property (req_in.wr && req_in.addr == 8'h17 && req_in.wdata[1] && !device_reset_out
    |=> device_reset_out)
    else $error("soft reset write gave no pulse");
  chk_reset_pulse: assert property (device_reset_out |=> !device_reset_out)
    else $error("soft reset bit did not clear");
  chk_reset_clears: assert property (device_reset_out |-> ##2 (gain_out == '0 && dac_low_power_out == 3'h0))
    else $error("soft reset left controls set");
  chk_gain_range: assert property (gain_out.group_a >= -8'sd64 && gain_out.group_a <= 8'sd64
    && gain_out.group_b >= -8'sd64 && gain_out.group_b <= 8'sd64)
    else $error("gain beyond trim range");

  cov_read: cover property (req_in.rd ##1 rvalid_out);
  cov_soft_reset: cover property (device_reset_out);
  cov_low_power: cover property (dac_low_power_out == 3'h7);
endmodule : dcr_bank_properties

bind dcr_bank dcr_bank_properties dcr_bank_properties_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
  .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .gain_out(gain_out),
  .dac_low_power_out(dac_low_power_out), .device_reset_out(device_reset_out));

/* tb/dcr_bank_tb.sv */
// self-checking bench for the converter control bank
`timescale 1ns/1ps
module dcr_bank_tb;
  logic                    clk_sys_in = 1'b0;
  logic                    rst_n_in = 1'b0;
  dcr_pkg::dcr_req_t       req_in = '0;
  logic [9:0]              sd_bus_in = '0;
  logic [9:0]              luma_bus_in = '0;
  logic [9:0]              chroma_bus_in = '0;
  dcr_pkg::dcr_ctrl_pins_t ctrl_pins_in = '0;
  logic                    dac1_unconnected_in = 1'b0;
  logic                    dac2_unconnected_in = 1'b0;
  logic [7:0]              rdata_out;
  logic                    rvalid_out;
  dcr_pkg::dcr_gain_t      gain_out;
  logic [2:0]              dac_low_power_out;
  logic                    device_reset_out;
  int                      num_errors = 0;
  int                      n_checks = 0;
  logic [7:0]              ctl [7] = '{8'h0A, 8'h0B, 8'h0D, 8'h10, 8'h17, 8'h0C, 8'h11};
  logic [7:0]              pin_exp [5] = '{8'hA9, 8'h56, 8'hFF, 8'h1B, 8'h2D};

  always #2 clk_sys_in = ~clk_sys_in;

  dcr_bank #(.BUS_WIDTH(10)) dcr_bank_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .req_in(req_in),
    .sd_bus_in(sd_bus_in), .luma_bus_in(luma_bus_in), .chroma_bus_in(chroma_bus_in),
    .ctrl_pins_in(ctrl_pins_in), .dac1_unconnected_in(dac1_unconnected_in),
    .dac2_unconnected_in(dac2_unconnected_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
    .gain_out(gain_out), .dac_low_power_out(dac_low_power_out), .device_reset_out(device_reset_out));

  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_in);
    req_in = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys_in);
    req_in = '0;
  endtask : wr

  // the answer stands one cycle only, so it is taken at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_in);
    req_in = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys_in);
    req_in = '0;
    chk("rvalid", 8'h01, {7'h00, rvalid_out});
    chk("rdata", exp, rdata_out);
  endtask : rd

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #20000;
    num_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (5) @(negedge clk_sys_in);
    rst_n_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    foreach (ctl[i]) rd(ctl[i], 8'h00);
    wr(8'h0A, 8'h7F);
    rd(8'h0A, 8'h7F);
    chk("gain_b", 8'h40, gain_out.group_b);
    wr(8'h0B, 8'h81);
    // the clamped gain leaves its output flop one cycle after the register takes the write
    @(negedge clk_sys_in);
    chk("gain_a", 8'hC0, gain_out.group_a);
    wr(8'h0B, 8'hC3);
    rd(8'h0B, 8'hC3);
    chk("gain_a", 8'hC3, gain_out.group_a);
    wr(8'h0D, 8'hFF);
    rd(8'h0D, 8'h07);
    chk("low_power", 8'h07, {5'h00, dac_low_power_out});
    wr(8'h0D, 8'h02);
    rd(8'h0D, 8'h02);
    chk("low_power", 8'h02, {5'h00, dac_low_power_out});
    wr(8'h0D, 8'h00);
    // pins pass a two-flop synchroniser, so give them time to land
    dac1_unconnected_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    rd(8'h10, 8'h01);
    chk("low_power", 8'h00, {5'h00, dac_low_power_out});
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h11);
    chk("low_power", 8'h01, {5'h00, dac_low_power_out});
    dac1_unconnected_in = 1'b0;
    dac2_unconnected_in = 1'b1;
    repeat (4) @(negedge clk_sys_in);
    rd(8'h10, 8'h12);
    chk("low_power", 8'h02, {5'h00, dac_low_power_out});
    wr(8'h10, 8'h00);
    rd(8'h10, 8'h02);
    chk("low_power", 8'h00, {5'h00, dac_low_power_out});
    sd_bus_in = 10'h2A5;
    luma_bus_in = 10'h15A;
    chroma_bus_in = 10'h3FF;
    ctrl_pins_in = 6'h2D;
    repeat (4) @(negedge clk_sys_in);
    for (int i = 0; i < 5; i++) begin
      wr(8'h12 + 8'(i), 8'h00);
      rd(8'h12 + 8'(i), pin_exp[i]);
    end
    wr(8'h0D, 8'h05);
    wr(8'h17, 8'h01);
    chk("soft_reset", 8'h00, {7'h00, device_reset_out});
    wr(8'h17, 8'h02);
    chk("soft_reset", 8'h01, {7'h00, device_reset_out});
    rd(8'h17, 8'h00);
    chk("gain_a", 8'h00, gain_out.group_a);
    chk("gain_b", 8'h00, gain_out.group_b);
    chk("low_power", 8'h00, {5'h00, dac_low_power_out});
    print_verdict();
  end
endmodule : dcr_bank_tb
